// File: hw/spi_usart_pkg.sv
// Contract
// [R1] Phase bit set delays the serial clock half a period against the data.
// [R2] Polarity clear: clock idles low, data out on rising, sampled on falling.
// [R3] Polarity set: clock idles high, data out on falling, sampled on rising.
// [R4] Source field: 00 external clock (slave), 01 auxiliary, 1x sub-main (master).
// [R5] Pin mode clear is four-pin with slave enable; set is three-pin, enable ignored.
// [R6] Transmitter-empty reads 1 only when buffer and shift register are empty.
// [R7] Master in four-pin mode: falling slave enable sets the bus conflict flag.
// [R8] Overrun sets when a new character lands before the previous one was read.
// [R9] Overrun clears on buffer read, on soft reset, or by software write.
// [R10] Baud divisor is sixteen bits: high register bits 15..8, low bits 7..0.
// [R11] Software keeps the divisor at two or more.
// [R12] Software writes the modulation register to zero; it has no effect.
// [R13] Receive buffer holds the last character; reading clears overrun and rx flag.
// [R14] Seven-bit characters are right-justified, buffer top bit reads zero.
// [R15] Software left-justifies seven-bit characters before writing the transmit buffer.
// [R16] Characters shift out most significant bit first.
// [R17] Any transmit buffer write clears the transmit interrupt flag; a write in a load cycle or under soft reset leaves it set.
// [R18] Port enables: bit 6 of first enable register, bit 4 of second.
// [R19] Port 0 interrupt enables: transmit bit 7, receive bit 6 of first register.
// [R20] Port 1 interrupt enables: transmit bit 5, receive bit 4 of second register.
// [R21] Transmit flag at bit 7 of first flag register, set when empty, resets to 1.
// [R22] Receive flag at bit 6 of first flag register, set on a complete character.
// [R23] Soft reset bit holds all port logic in reset until cleared.
// [R24] Master select 1 drives the serial clock; 0 takes it from outside.
// [R25] Master clock is source divided by divisor, at most half the source rate.
// [R26] Idle enabled shifter takes a buffered character; transmit flag sets again.
package spi_usart_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BAUD_DIV_W = 16;

    // Byte offsets of the word-aligned registers
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TCTL   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RCTL   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MCTL   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_BR_LO  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_BR_HI  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RXBUF  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_TXBUF  = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_ME_ONE = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_ME_TWO = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_IE_ONE = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_IE_TWO = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_IFG    = 8'h30;

    // Field positions
    localparam int CTRL_CHAR_BIT   = 4;
    localparam int CTRL_MASTER_BIT = 1;
    localparam int CTRL_SRST_BIT   = 0;
    localparam int TCTL_PHASE_BIT  = 7;
    localparam int TCTL_POL_BIT    = 6;
    localparam int TCTL_SEL_HI     = 5;
    localparam int TCTL_SEL_LO     = 4;
    localparam int TCTL_PIN_BIT    = 1;
    localparam int TCTL_EMPTY_BIT  = 0;
    localparam int RCTL_CONFL_BIT  = 7;
    localparam int RCTL_OVRUN_BIT  = 5;
    localparam int EN1_SYNC_BIT    = 6;
    localparam int EN2_SYNC_BIT    = 4;
    localparam int IEN1_TX_BIT     = 7;
    localparam int IEN1_RX_BIT     = 6;
    localparam int IEN2_TX_BIT     = 5;
    localparam int IEN2_RX_BIT     = 4;
    localparam int IFG_TX_BIT      = 7;
    localparam int IFG_RX_BIT      = 6;

    // Reset values and writable masks
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [7:0] CTRL_WMASK = 8'h3f;
    localparam logic [7:0] TCTL_WMASK = 8'hf2;
    localparam logic [7:0] IFG_RESET  = 8'h80;

    localparam logic [1:0] SRC_EXT = 2'b00;
    localparam logic [1:0] SRC_AUX = 2'b01;
    localparam logic [3:0] CHAR8_BITS = 4'h8;
    localparam logic [3:0] CHAR7_BITS = 4'h7;

    typedef enum logic [1:0] {
        XFER_IDLE  = 2'b01,
        XFER_SHIFT = 2'b10
    } xfer_state_t;
endpackage : spi_usart_pkg

// File: hw/baud_tick_gen.sv
`timescale 1ns/1ps
module baud_tick_gen #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // Control
    input  wire logic             run,
    input  wire logic             src_tick,
    input  wire logic [DIV_W-1:0] divisor,
    // Two pulses per baud period
    output logic                  half_tick
);
    localparam logic [DIV_W-1:0] ONE = 1;
    logic [DIV_W-1:0] cnt_r;

    // Odd divisors give unequal halves; period stays exact
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r     <= '0;
            half_tick <= 1'b0;
        end else begin
            half_tick <= 1'b0;
            if (!run) begin
                cnt_r <= '0;
            end else if (src_tick) begin
                if (cnt_r == divisor - ONE) begin // R10 R25
                    cnt_r     <= '0;
                    half_tick <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + ONE;
                    if (cnt_r == (divisor >> 1) - ONE) begin
                        half_tick <= 1'b1;
                    end
                end
            end
        end
    end
endmodule : baud_tick_gen

// File: hw/pin_edge.sv
`timescale 1ns/1ps
module pin_edge #(
    parameter logic IDLE = 1'b0
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Level in, edges out
    input  wire logic level,
    output logic      rise,
    output logic      fall
);
    logic prev_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= IDLE;
        end else begin
            prev_r <= level;
        end
    end

    assign rise = level & ~prev_r;
    assign fall = ~level & prev_r;
endmodule : pin_edge

// File: hw/usart_spi_port.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module usart_spi_port (
    // Clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           reset_n,
    // APB slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [spi_usart_pkg::ADDR_W-1:0] paddr,
    input  wire logic [spi_usart_pkg::DATA_W-1:0] pwdata,
    output logic      [spi_usart_pkg::DATA_W-1:0] prdata,
    output logic                                pready,
    output logic                                pslverr,
    // Auxiliary baud source, one-cycle enable
    input  wire logic                           aux_clk_tick,
    // Serial pins
    input  wire logic                           sclk_in,
    output logic                                sclk_out,
    output logic                                sclk_oe_n,
    input  wire logic                           simo_in,
    output logic                                simo_out,
    output logic                                simo_oe_n,
    input  wire logic                           somi_in,
    output logic                                somi_out,
    output logic                                somi_oe_n,
    input  wire logic                           slave_enable_pin,
    // Interrupt requests and port 1 enables
    output logic                                tx_irq_req,
    output logic                                rx_irq_req,
    output logic                                port1_sync_enable,
    output logic                                port1_tx_irq_enable,
    output logic                                port1_rx_irq_enable
);
    import spi_usart_pkg::*;

    logic [7:0]  ctrl_r, tctl_r, mctl_r, br0_r, br1_r, rxbuf_r, txbuf_r;
    logic [7:0]  en1_r, en2_r, ien1_r, ien2_r, ifg_r, ifg_nxt;
    logic        conflict_r, overrun_r, txbuf_full_r, sampled_r, dout_r;
    logic [7:0]  tx_sh_r, rx_sh_r, rx_sh_nxt, rd_mux;
    logic [3:0]  bit_cnt_r, nbits;
    logic [4:0]  tog_cnt_r;
    logic        rd_ok, half_tick, s_rise, s_fall, sen_rise, sen_fall;
    xfer_state_t state_r;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////
    // Control decode
    wire soft_reset = ctrl_r[CTRL_SRST_BIT];
    wire master     = ctrl_r[CTRL_MASTER_BIT]; // R24
    wire char8      = ctrl_r[CTRL_CHAR_BIT];
    wire phase      = tctl_r[TCTL_PHASE_BIT];
    wire pol        = tctl_r[TCTL_POL_BIT];
    wire pin_mode   = tctl_r[TCTL_PIN_BIT];
    wire [1:0] sel  = tctl_r[TCTL_SEL_HI:TCTL_SEL_LO];
    wire sync_en    = en1_r[EN1_SYNC_BIT]; // R18
    wire eng_rst    = soft_reset | ~sync_en; // R23

    // Slave listens only while selected in four-pin mode
    wire selected   = master | pin_mode | ~slave_enable_pin; // R5
    wire slave_on   = ~master & selected & ~eng_rst;
    wire shifting   = (state_r == XFER_SHIFT);
    wire tx_empty   = ~txbuf_full_r & ~shifting; // R6

    ////////////////////////////////////////////////////////////////////
    // APB decode
    wire setup    = psel & ~penable;
    wire acc_done = psel & penable & pready;
    wire wr_en    = acc_done & pwrite;
    wire rd_en    = acc_done & ~pwrite;
    wire wr_ctrl  = wr_en & hit(paddr, OFS_CTRL);
    wire wr_tctl  = wr_en & hit(paddr, OFS_TCTL);
    wire wr_rctl  = wr_en & hit(paddr, OFS_RCTL);
    wire wr_txbuf = wr_en & hit(paddr, OFS_TXBUF);
    wire wr_ifg   = wr_en & hit(paddr, OFS_IFG);
    wire wr_ien1  = wr_en & hit(paddr, OFS_IE_ONE);
    wire rd_rxbuf = rd_en & hit(paddr, OFS_RXBUF);
    wire [7:0] wbyte = pwdata[7:0];

    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = 8'h00;
        unique case (paddr)
            OFS_CTRL:   rd_mux = ctrl_r;
            OFS_TCTL:   rd_mux = {tctl_r[7:1], tx_empty};
            OFS_RCTL:   rd_mux = {conflict_r, 1'b0, overrun_r, 5'h00};
            OFS_MCTL:   rd_mux = mctl_r;
            OFS_BR_LO:  rd_mux = br0_r;
            OFS_BR_HI:  rd_mux = br1_r;
            OFS_RXBUF:  rd_mux = rxbuf_r;
            OFS_TXBUF:  rd_mux = txbuf_r;
            OFS_ME_ONE: rd_mux = en1_r;
            OFS_ME_TWO: rd_mux = en2_r;
            OFS_IE_ONE: rd_mux = ien1_r;
            OFS_IE_TWO: rd_mux = ien2_r;
            OFS_IFG:    rd_mux = ifg_r;
            default:    rd_ok  = 1'b0;
        endcase
    end

    // Zero-wait slave: answer registered in the setup cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~rd_ok;
            if (setup) begin
                prdata <= (!pwrite && rd_ok) ? {24'h000000, rd_mux} : '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock generation and edge selection
    baud_tick_gen #(.DIV_W(BAUD_DIV_W)) u_baud (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .run      (master & shifting & ~eng_rst),
        .src_tick ((sel == SRC_AUX) ? aux_clk_tick : sel[1]), // R4
        .divisor  ({br1_r, br0_r}), // R10
        .half_tick(half_tick)
    );

    pin_edge #(.IDLE(1'b0)) u_sclk_edge (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .level  (sclk_in),
        .rise   (s_rise),
        .fall   (s_fall)
    );

    pin_edge #(.IDLE(1'b1)) u_sen_edge (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .level  (slave_enable_pin),
        .rise   (sen_rise),
        .fall   (sen_fall)
    );

    // Master edges come from the toggle itself so data and clock move together
    wire m_tick   = half_tick & shifting & master;
    wire rise     = master ? (m_tick & ~sclk_out) : (s_rise & slave_on);
    wire fall     = master ? (m_tick & sclk_out) : (s_fall & slave_on);
    // Delayed phase swaps which edge samples
    wire smp_rise = pol ^ phase; // R1
    wire smp_edge = smp_rise ? rise : fall; // R2 R3
    wire out_edge = smp_rise ? fall : rise; // R2 R3
    wire din      = master ? somi_in : simo_in;
    wire rx_act   = master ? shifting : slave_on;

    assign nbits     = char8 ? CHAR8_BITS : CHAR7_BITS;
    assign rx_sh_nxt = {rx_sh_r[6:0], din};

    wire rx_done    = smp_edge & rx_act & (bit_cnt_r == nbits - 4'h1);
    wire load_go    = ~shifting & txbuf_full_r & ~eng_rst
                      & (master | (slave_on & (bit_cnt_r == 4'h0))); // R26
    wire master_end = m_tick & (tog_cnt_r == {nbits, 1'b0} - 5'h01);
    wire xfer_end   = shifting & (master ? master_end : rx_done);

    ////////////////////////////////////////////////////////////////////
    // Shift engine
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r   <= XFER_IDLE;
            tx_sh_r   <= '0;
            rx_sh_r   <= '0;
            bit_cnt_r <= '0;
            tog_cnt_r <= '0;
            sampled_r <= 1'b0;
            sclk_out  <= 1'b0;
            dout_r    <= 1'b0;
        end else if (eng_rst) begin // R23
            state_r   <= XFER_IDLE;
            bit_cnt_r <= '0;
            tog_cnt_r <= '0;
            sampled_r <= 1'b0;
            sclk_out  <= pol;
        end else begin
            if (!master && !selected) begin
                bit_cnt_r <= '0;
                sampled_r <= 1'b0;
            end
            if (!shifting) begin
                sclk_out <= pol; // R2 R3
            end
            if (load_go) begin
                state_r   <= XFER_SHIFT;
                tx_sh_r   <= txbuf_r;
                dout_r    <= txbuf_r[7]; // R16
                tog_cnt_r <= '0;
                sampled_r <= 1'b0;
            end else begin
                if (m_tick) begin
                    sclk_out  <= ~sclk_out; // R25
                    tog_cnt_r <= tog_cnt_r + 5'h01;
                end
                if (smp_edge && rx_act) begin
                    rx_sh_r   <= rx_sh_nxt;
                    bit_cnt_r <= rx_done ? 4'h0 : bit_cnt_r + 4'h1;
                    sampled_r <= 1'b1;
                end
                if (out_edge && sampled_r && shifting) begin
                    tx_sh_r   <= {tx_sh_r[6:0], 1'b0}; // R16
                    dout_r    <= tx_sh_r[6];
                    sampled_r <= 1'b0;
                end
                if (xfer_end) begin
                    state_r <= XFER_IDLE;
                end
            end
        end
    end

    assign simo_out = dout_r;
    assign somi_out = dout_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_oe_n <= 1'b1;
            simo_oe_n <= 1'b1;
            somi_oe_n <= 1'b1;
        end else begin
            sclk_oe_n <= ~(master & ~eng_rst); // R24
            simo_oe_n <= ~(master & ~eng_rst);
            somi_oe_n <= ~slave_on;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= CTRL_RESET;
            tctl_r <= 8'h00;
            mctl_r <= 8'h00;
            br0_r  <= 8'h00;
            br1_r  <= 8'h00;
            en1_r  <= 8'h00;
            en2_r  <= 8'h00;
            ien2_r <= 8'h00;
        end else begin
            if (wr_ctrl) ctrl_r <= wbyte & CTRL_WMASK;
            if (wr_tctl) tctl_r <= wbyte & TCTL_WMASK;
            if (wr_en && hit(paddr, OFS_MCTL)) mctl_r <= wbyte; // R12
            if (wr_en && hit(paddr, OFS_BR_LO)) br0_r <= wbyte; // R10
            if (wr_en && hit(paddr, OFS_BR_HI)) br1_r <= wbyte; // R10
            if (wr_en && hit(paddr, OFS_ME_ONE)) en1_r <= wbyte; // R18
            if (wr_en && hit(paddr, OFS_ME_TWO)) en2_r <= wbyte; // R18
            if (wr_en && hit(paddr, OFS_IE_TWO)) ien2_r <= wbyte; // R20
        end
    end

    // Port 0 interrupt enables drop under soft reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ien1_r <= 8'h00;
        end else if (wr_ien1) begin
            ien1_r <= wbyte;
        end else if (soft_reset) begin
            ien1_r[IEN1_TX_BIT] <= 1'b0;
            ien1_r[IEN1_RX_BIT] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data buffers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            txbuf_r      <= 8'h00;
            txbuf_full_r <= 1'b0;
        end else begin
            if (load_go || soft_reset) begin
                txbuf_full_r <= 1'b0;
            end
            // New data wins over a same-cycle load
            if (wr_txbuf) begin
                txbuf_r      <= wbyte;
                txbuf_full_r <= ~soft_reset; // R23
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxbuf_r <= 8'h00;
        end else if (rx_done) begin // R13
            rxbuf_r <= char8 ? rx_sh_nxt : {1'b0, rx_sh_nxt[6:0]}; // R14
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status flags; hardware set wins over every clear but soft reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            overrun_r  <= 1'b0;
            conflict_r <= 1'b0;
        end else if (soft_reset) begin
            overrun_r  <= 1'b0; // R9
            conflict_r <= 1'b0;
        end else begin
            if (rx_done && ifg_r[IFG_RX_BIT]) begin
                overrun_r <= 1'b1; // R8
            end else if (rd_rxbuf) begin
                overrun_r <= 1'b0; // R9 R13
            end else if (wr_rctl) begin
                overrun_r <= wbyte[RCTL_OVRUN_BIT]; // R9
            end
            if (master && !pin_mode && sen_fall) begin
                conflict_r <= 1'b1; // R7
            end else if (wr_rctl) begin
                conflict_r <= wbyte[RCTL_CONFL_BIT];
            end
        end
    end

    always_comb begin
        ifg_nxt = wr_ifg ? wbyte : ifg_r;
        if (rd_rxbuf) ifg_nxt[IFG_RX_BIT] = 1'b0; // R13
        if (wr_txbuf) ifg_nxt[IFG_TX_BIT] = 1'b0; // R17
        if (load_go) ifg_nxt[IFG_TX_BIT] = 1'b1; // R21 R26
        if (rx_done) ifg_nxt[IFG_RX_BIT] = 1'b1; // R22
        if (soft_reset) begin
            ifg_nxt[IFG_TX_BIT] = 1'b1;
            ifg_nxt[IFG_RX_BIT] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ifg_r <= IFG_RESET; // R21
        end else begin
            ifg_r <= ifg_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_irq_req          <= 1'b0;
            rx_irq_req          <= 1'b0;
            port1_sync_enable   <= 1'b0;
            port1_tx_irq_enable <= 1'b0;
            port1_rx_irq_enable <= 1'b0;
        end else begin
            tx_irq_req          <= ifg_r[IFG_TX_BIT] & ien1_r[IEN1_TX_BIT]; // R19
            rx_irq_req          <= ifg_r[IFG_RX_BIT] & ien1_r[IEN1_RX_BIT]; // R19
            port1_sync_enable   <= en2_r[EN2_SYNC_BIT];
            port1_tx_irq_enable <= ien2_r[IEN2_TX_BIT]; // R20
            port1_rx_irq_enable <= ien2_r[IEN2_RX_BIT]; // R20
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_sclk_idle_level: assert property ( // R2
        master && !shifting && !eng_rst |=> !shifting || sclk_out == $past(pol))
        else $error("idle serial clock not at polarity level");
    a_msb_first_out: assert property ( // R16
        load_go |=> simo_out == $past(txbuf_r[7]) && shifting)
        else $error("first bit out is not the msb");
    a_txwr_clears_flag: assert property ( // R17
        wr_txbuf && !load_go && !soft_reset |=> !ifg_r[IFG_TX_BIT])
        else $error("transmit write left flag set");
    a_overrun_on_unread: assert property ( // R8
        rx_done && ifg_r[IFG_RX_BIT] && !soft_reset |=> overrun_r)
        else $error("overrun missed");
    a_rxread_clears: assert property ( // R13
        rd_rxbuf && !rx_done && !soft_reset |=> !overrun_r && !ifg_r[IFG_RX_BIT])
        else $error("receive read did not clear flags");
    a_soft_reset_hold: assert property ( // R23
        soft_reset [*2] |-> !shifting && ifg_r[IFG_TX_BIT] && !txbuf_full_r)
        else $error("port not held under soft reset");
    a_conflict_edge: assert property ( // R7
        master && !pin_mode && sen_fall && !soft_reset |=> conflict_r)
        else $error("bus conflict not flagged");
    a_seven_bit_msb: assert property ( // R14
        rx_done && !char8 |=> rxbuf_r[7] == 1'b0)
        else $error("seven bit character not right justified");
    a_load_sets_flag: assert property ( // R26
        load_go && !soft_reset |=> ifg_r[IFG_TX_BIT] && !txbuf_full_r == !$past(wr_txbuf))
        else $error("load did not reset transmit flag");
    a_empty_flag: assert property ( // R6
        wr_txbuf && !soft_reset |=> !tx_empty [*2])
        else $error("empty flag high with data waiting");

    c_master_done: cover property (master && xfer_end);
    c_slave_done:  cover property (!master && rx_done);
    c_overrun:     cover property (rx_done && ifg_r[IFG_RX_BIT]);
    c_conflict:    cover property (master && !pin_mode && sen_fall);
endmodule : usart_spi_port

// File: bench/spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model #(
    parameter logic [7:0] TX_BYTE = 8'h3c
) (
    // Serial pins
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       sel,
    output logic            miso,
    // Captured character
    output logic [7:0]      rx
);
    logic [2:0] cnt = 3'h0;
    logic [2:0] pos = 3'h0;
    // Mode 0 only: sample on the falling edge
    always @(negedge sclk or negedge sel) begin
        if (!sel) begin
            cnt <= 3'h0;
        end else begin
            rx  <= {rx[6:0], mosi};
            cnt <= cnt + 3'h1;
        end
    end
    always @(posedge sclk or negedge sel) begin
        if (!sel) begin
            pos <= 3'h0;
        end else begin
            pos <= cnt;
        end
    end
    // Deselected line shows the inverse so a stale bit never matches
    assign miso = sel ? TX_BYTE[~pos] : ~TX_BYTE[~pos];
endmodule : spi_slave_model

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
    import spi_usart_pkg::*;
    logic              sys_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, aux = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rdata;
    logic              pready, pslverr, slverr, sclk_out, simo_out, somi, txirq;
    logic              sel = 1'b0, sen = 1'b1, s_clk = 1'b0, s_din = 1'b0, s_dout;
    logic [7:0]        prx;
    int                err_count = 0, check_count = 0;
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) aux <= ~aux;
    usart_spi_port usart_spi_port_inst (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .aux_clk_tick(aux), .sclk_in(s_clk),
        .sclk_out(sclk_out), .sclk_oe_n(), .simo_in(s_din), .simo_out(simo_out), .simo_oe_n(),
        .somi_in(somi), .somi_out(s_dout), .somi_oe_n(), .slave_enable_pin(sen),
        .tx_irq_req(txirq), .rx_irq_req(), .port1_sync_enable(), .port1_tx_irq_enable(),
        .port1_rx_irq_enable());
    spi_slave_model spi_slave_model_inst (.sclk(sclk_out), .mosi(simo_out), .sel(sel),
        .miso(somi), .rx(prx));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdata   = prdata;
        slverr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 8'h00);
        chk(nm, rdata, exp);
    endtask : rd
    task automatic send(input logic [7:0] b);
        apb(1'b1, OFS_TXBUF, b);
        apb(1'b0, OFS_TCTL, 8'h00);
        chk("tx_all_empty", {31'h0, rdata[0]}, 32'h0);
        for (int i = 0; i < 200 && rdata[0] !== 1'b1; i++) apb(1'b0, OFS_TCTL, 8'h00);
        chk("tx_all_empty", {31'h0, rdata[0]}, 32'h1);
    endtask : send
    task automatic t_reset;
        rd(OFS_CTRL, {24'h0, CTRL_RESET}, "ctrl");
        rd(OFS_TCTL, 32'h01, "tctl");
        rd(OFS_IFG, {24'h0, IFG_RESET}, "ifg");
        apb(1'b0, 8'h40, 8'h00);
        chk("unmapped", {31'h0, slverr}, 32'h1);
    endtask : t_reset
    task automatic t_master;
        apb(1'b1, OFS_TCTL, 8'h22);
        apb(1'b1, OFS_BR_LO, 8'h02);
        apb(1'b1, OFS_BR_HI, 8'h00);
        apb(1'b1, OFS_MCTL, 8'h00);
        apb(1'b1, OFS_ME_ONE, 8'h40);
        apb(1'b1, OFS_CTRL, 8'h12);
        apb(1'b1, OFS_IE_ONE, 8'h80);
        @(posedge sys_clk);
        chk("sclk_idle", {31'h0, sclk_out}, 32'h0);
        chk("tx_irq", {31'h0, txirq}, 32'h1);
        send(8'ha5);
        chk("partner_rx", {24'h0, prx}, 32'ha5);
        rd(OFS_IFG, 32'hc0, "ifg");
        rd(OFS_RXBUF, 32'h3c, "rxbuf");
        rd(OFS_IFG, 32'h80, "ifg");
    endtask : t_master
    task automatic t_overrun;
        apb(1'b1, OFS_TCTL, 8'h12);
        send(8'h5a);
        send(8'h5a);
        rd(OFS_RCTL, 32'h20, "overrun");
        rd(OFS_RXBUF, 32'h3c, "rxbuf");
        rd(OFS_RCTL, 32'h00, "overrun");
    endtask : t_overrun
    task automatic t_sevenbit;
        apb(1'b1, OFS_CTRL, 8'h02);
        send(8'ha4);
        chk("partner_rx7", {25'h0, prx[6:0]}, 32'h52);
        rd(OFS_RXBUF, 32'h1e, "rxbuf7");
    endtask : t_sevenbit
    task automatic t_pins;
        apb(1'b1, OFS_TCTL, 8'h60);
        @(posedge sys_clk);
        chk("sclk_idle", {31'h0, sclk_out}, 32'h1);
        apb(1'b1, OFS_TCTL, 8'h20);
        sen <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(OFS_RCTL, 32'h80, "conflict");
        apb(1'b1, OFS_CTRL, 8'h13);
        rd(OFS_RCTL, 32'h00, "rctl_srst");
        rd(OFS_IFG, 32'h80, "ifg_srst");
    endtask : t_pins
    task automatic t_slave;
        logic [7:0] got = 8'h00, dv = 8'h96;
        apb(1'b1, OFS_CTRL, 8'h10);
        apb(1'b1, OFS_TXBUF, 8'hc3);
        for (int b = 7; b >= 0; b--) begin
            s_din <= dv[b];
            s_clk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            got = {got[6:0], s_dout};
            s_clk <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        chk("slave_out", {24'h0, got}, 32'hc3);
        rd(OFS_RXBUF, 32'h96, "slave_rx");
    endtask : t_slave
    task automatic finish_test;
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        sel     <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_master();
        t_overrun();
        t_sevenbit();
        t_pins();
        t_slave();
        finish_test();
    end
endmodule : tb
